// [design/mss_pkg.sv]
// package: constants and types of the multi-step speed sequencer
package mss_pkg;

  localparam int unsigned NUM_STEPS = 16;
  localparam int unsigned STEP_W    = 4;
  localparam int unsigned REF_W     = 11;  // signed, 0.1 % units
  localparam int unsigned DUR_W     = 16;  // 0.1 s or 0.1 h units
  localparam int unsigned RAMP_W    = 2;
  localparam int unsigned BASE_W    = 16;
  localparam int unsigned PRE_W     = 24;
  localparam int unsigned HCNT_W    = 12;

  // full scale of a step reference, 100.0 % in 0.1 % units
  localparam logic [9:0] REF_FULL       = 10'h3E8;
  localparam logic [REF_W-1:0] REF_RST  = 11'h000;
  localparam logic [DUR_W-1:0] DUR_MAX  = 16'hFDE8;  // 6500.0
  localparam logic [STEP_W-1:0] STEP_FIRST = 4'h0;
  localparam logic [STEP_W-1:0] STEP_LAST  = 4'hF;

  // sequence_run_mode encodings
  localparam logic [1:0] MODE_STOP_END = 2'h0;
  localparam logic [1:0] MODE_HOLD_END = 2'h1;
  localparam logic [1:0] MODE_REPEAT   = 2'h2;

  // sequence_retention_select bit positions
  localparam int unsigned RET_PWR_BIT  = 0;  // units digit
  localparam int unsigned RET_STOP_BIT = 1;  // tens digit

  // output target encodings
  localparam logic [1:0] TGT_FREQ = 2'h0;
  localparam logic [1:0] TGT_VOLT = 2'h1;
  localparam logic [1:0] TGT_PID  = 2'h2;

  // step0_source_select encodings
  localparam logic [2:0] SRC_STORED = 3'h0;
  localparam logic [2:0] SRC_LAST   = 3'h6;

  // timing: the duration unit is a tenth of a second or of an hour
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TENTH_SEC_NS  = 100_000_000;
  localparam int unsigned TENTH_SEC_CYC = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_HOUR  = 3600;
  localparam logic [HCNT_W-1:0] HCNT_LAST = HCNT_W'(SEC_PER_HOUR - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_HOLD
  } mss_state_t;

  typedef struct packed {
    mss_state_t        state;
    logic [STEP_W-1:0] step;
    logic [DUR_W-1:0]  elapsed;
    logic [PRE_W-1:0]  pre;
    logic [HCNT_W-1:0] hcnt;
    logic [STEP_W-1:0] rec_step;
    logic [DUR_W-1:0]  rec_elapsed;
    logic [BASE_W-1:0] rec_freq;
    logic              rec_valid;
    logic              rec_pwr;
    logic              boot;
    logic              nv_save;
    logic              drive_run;
    logic              dir_rev;
    logic [BASE_W-1:0] freq_ref;
    logic [BASE_W-1:0] volt_ref;
    logic [REF_W-1:0]  pid_sp;
    logic [RAMP_W-1:0] ramp_sel;
    logic              pass_done;
  } mss_st_t;

endpackage : mss_pkg

// [design/mss_scale.sv]
// module: scales a signed step reference against a full-scale base
`timescale 1ns/1ps
`default_nettype none
module mss_scale (
  input  wire logic signed [mss_pkg::REF_W-1:0]  ref_in,
  input  wire logic        [mss_pkg::BASE_W-1:0] base,
  output logic             [mss_pkg::BASE_W-1:0] mag,
  output logic                                   neg
);
  import mss_pkg::*;

  logic [9:0]  abs_ref;
  logic [25:0] prod;

  // clamp to full scale so the result never exceeds the base
  always_comb begin
    abs_ref = ref_in[REF_W-1] ? 10'((-ref_in)) : ref_in[9:0];
    if (abs_ref > REF_FULL || (ref_in[REF_W-1] && ref_in[9:0] == 10'h000
        && ref_in != REF_RST)) begin
      abs_ref = REF_FULL;
    end
    prod = 26'(abs_ref) * 26'(base);
    mag  = BASE_W'(prod / 26'(REF_FULL));
    neg  = ref_in[REF_W-1];
  end

endmodule : mss_scale
`default_nettype wire

// [design/mss_sequencer.sv]
// module: multi-step reference sequencer, timed or terminal selected
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - mode 0 halts the drive after one pass until a new run command.
// - mode 1 holds final reference and direction after one pass.
// - mode 2 restarts at step 0 after each pass until stopped.
// - in frequency use a negative step selects reverse, positive forward.
// - power retention saves position and frequency, resumes after power-up.
// - without power retention the sequence restarts after power returns.
// - stop retention records position and frequency, continues on start.
// - without stop retention a start begins at step 0; default off.
// - sixteen signed step references, -100.0 to 100.0 percent, default 0.
// - frequency use scales a step against maximum output frequency.
// - voltage use scales a step against rated motor voltage.
// - regulator setpoint use passes the step value unchanged.
// - input terminals may select the active step instead of timing.
// - each step has its own duration, 0.0 to 6500.0 units.
// - each step carries a 2-bit ramp time set selector.
// - timed output serves as frequency or separated voltage reference.
// - a time unit bit reads durations as seconds or hours.
// - step 0 source is stored, analog, pulse, regulator or keypad.
module mss_sequencer #(
  parameter int unsigned TENTH_CYC = mss_pkg::TENTH_SEC_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic [1:0]                  sequence_run_mode,
  input  wire logic [1:0]                  sequence_retention_select,
  input  wire logic [mss_pkg::NUM_STEPS-1:0][mss_pkg::REF_W-1:0] step_reference,
  input  wire logic [mss_pkg::NUM_STEPS-1:0][mss_pkg::DUR_W-1:0] step_duration,
  input  wire logic [mss_pkg::NUM_STEPS-1:0][mss_pkg::RAMP_W-1:0] step_ramp_select,
  input  wire logic                        step_time_unit,
  input  wire logic [2:0]                  step0_source_select,
  input  wire logic [5:0][mss_pkg::REF_W-1:0] step0_alt_ref,
  input  wire logic [1:0]                  out_target,
  input  wire logic                        terminal_mode,
  input  wire logic [mss_pkg::STEP_W-1:0]  terminal_step,
  input  wire logic                        run_cmd,
  input  wire logic                        stop_cmd,
  input  wire logic                        power_fail,
  input  wire logic                        nv_valid,
  input  wire logic [mss_pkg::STEP_W-1:0]  nv_step,
  input  wire logic [mss_pkg::DUR_W-1:0]   nv_elapsed,
  input  wire logic [mss_pkg::BASE_W-1:0]  max_freq,
  input  wire logic [mss_pkg::BASE_W-1:0]  rated_volt,
  output logic                             drive_run,
  output logic                             dir_reverse,
  output logic [mss_pkg::BASE_W-1:0]       freq_ref,
  output logic [mss_pkg::BASE_W-1:0]       volt_ref,
  output logic [mss_pkg::REF_W-1:0]        pid_setpoint,
  output logic [mss_pkg::RAMP_W-1:0]       ramp_select,
  output logic [mss_pkg::STEP_W-1:0]       active_step,
  output logic                             pass_done,
  output logic                             nv_save,
  output logic [mss_pkg::STEP_W-1:0]       nv_save_step,
  output logic [mss_pkg::DUR_W-1:0]        nv_save_elapsed,
  output logic [mss_pkg::BASE_W-1:0]       nv_save_freq
);
  import mss_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TENTH_CYC - 1);

  logic [1:0]        rst_sync_ff;
  logic              rst_i_b;
  mss_st_t           q_ff;
  mss_st_t           nxt_q;
  logic [REF_W-1:0]  cur_ref;
  logic [DUR_W-1:0]  cur_dur;
  logic [BASE_W-1:0] f_mag;
  logic [BASE_W-1:0] v_mag;
  logic              f_neg;
  logic              tick;
  logic              ret_pwr;
  logic              ret_stop;
  logic              step_done;

  // reset is released through two flops so every state flop sees it cleanly
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_i_b = rst_sync_ff[1];

  assign ret_pwr  = sequence_retention_select[RET_PWR_BIT];
  assign ret_stop = sequence_retention_select[RET_STOP_BIT];

  // active reference; step 0 may come from another channel
  always_comb begin
    cur_ref = step_reference[q_ff.step];
    if (q_ff.step == STEP_FIRST && step0_source_select != SRC_STORED
        && step0_source_select <= SRC_LAST) begin
      cur_ref = step0_alt_ref[3'(step0_source_select - 3'h1)];
    end
    cur_dur = step_duration[q_ff.step];
  end

  // one scaler per physical quantity
  mss_scale u_freq_scale (
    .ref_in (cur_ref),
    .base   (max_freq),
    .mag    (f_mag),
    .neg    (f_neg)
  );

  mss_scale u_volt_scale (
    .ref_in (cur_ref),
    .base   (rated_volt),
    .mag    (v_mag),
    .neg    ()
  );

  // duration tick: tenth of a second, or 3600 of them in hour mode
  always_comb begin
    tick = (q_ff.pre == PRE_LAST)
           && (!step_time_unit || q_ff.hcnt == HCNT_LAST);
    step_done = tick && (DUR_W'(q_ff.elapsed + 16'h0001) >= cur_dur);
  end

  // next state of the whole sequencer
  always_comb begin
    nxt_q = q_ff;
    nxt_q.nv_save   = 1'b0;
    nxt_q.pass_done = 1'b0;
    nxt_q.boot      = 1'b0;

    // first cycle after reset: pick up the position saved at power loss
    if (q_ff.boot && ret_pwr && nv_valid) begin
      nxt_q.rec_step    = nv_step;
      nxt_q.rec_elapsed = nv_elapsed;
      nxt_q.rec_valid   = 1'b1;
      nxt_q.rec_pwr     = 1'b1;
    end

    unique case (q_ff.state)
      ST_IDLE: begin
        if (run_cmd && !stop_cmd) begin
          nxt_q.state     = ST_RUN;
          nxt_q.drive_run = 1'b1;
          nxt_q.pre       = '0;
          nxt_q.hcnt      = '0;
          nxt_q.rec_valid = 1'b0;
          nxt_q.rec_pwr   = 1'b0;
          if (q_ff.rec_valid && (ret_stop || q_ff.rec_pwr)) begin
            nxt_q.step    = q_ff.rec_step;
            nxt_q.elapsed = q_ff.rec_elapsed;
          end else begin
            nxt_q.step    = STEP_FIRST;
            nxt_q.elapsed = '0;
          end
        end
      end
      ST_RUN: begin
        if (terminal_mode) begin
          nxt_q.step = terminal_step;
        end else if (cur_dur == '0 || step_done) begin
          // zero duration skips; an elapsed duration advances
          nxt_q.elapsed = '0;
          nxt_q.pre     = '0;
          nxt_q.hcnt    = '0;
          if (q_ff.step != STEP_LAST) begin
            nxt_q.step = 4'(q_ff.step + 4'h1);
          end else begin
            nxt_q.pass_done = 1'b1;
            unique case (sequence_run_mode)
              MODE_HOLD_END: nxt_q.state = ST_HOLD;
              MODE_REPEAT:   nxt_q.step  = STEP_FIRST;
              default: begin
                nxt_q.state     = ST_IDLE;
                nxt_q.drive_run = 1'b0;
                nxt_q.step      = STEP_FIRST;
              end
            endcase
          end
        end else begin
          nxt_q.pre = PRE_W'(q_ff.pre + 24'h000001);
          if (q_ff.pre == PRE_LAST) begin
            nxt_q.pre  = '0;
            nxt_q.hcnt = (q_ff.hcnt == HCNT_LAST || !step_time_unit) ? '0
                         : HCNT_W'(q_ff.hcnt + 12'h001);
            if (tick) begin
              nxt_q.elapsed = DUR_W'(q_ff.elapsed + 16'h0001);
            end
          end
        end
        // outputs follow only steps that really run, so skips never glitch
        if (terminal_mode || cur_dur != '0) begin
          nxt_q.freq_ref = f_mag;
          nxt_q.dir_rev  = (out_target == TGT_FREQ) && f_neg;
          nxt_q.volt_ref = v_mag;
          nxt_q.pid_sp   = cur_ref;
          nxt_q.ramp_sel = step_ramp_select[q_ff.step];
        end
      end
      ST_HOLD: begin
        // final values stay frozen while the drive keeps running
      end
      default: begin
        nxt_q.state     = ST_IDLE;
        nxt_q.drive_run = 1'b0;
      end
    endcase

    // stop wins over a pass end in the same cycle
    if (stop_cmd && q_ff.state != ST_IDLE) begin
      nxt_q.state     = ST_IDLE;
      nxt_q.drive_run = 1'b0;
      nxt_q.rec_valid = ret_stop;
      nxt_q.rec_pwr   = 1'b0;
      nxt_q.rec_step    = q_ff.step;
      nxt_q.rec_elapsed = q_ff.elapsed;
      nxt_q.rec_freq    = q_ff.freq_ref;
      nxt_q.step        = STEP_FIRST;
      nxt_q.elapsed     = '0;
    end

    // power loss: hand the moment and frequency to non-volatile storage
    if (power_fail && ret_pwr) begin
      nxt_q.nv_save     = 1'b1;
      nxt_q.rec_step    = q_ff.step;
      nxt_q.rec_elapsed = q_ff.elapsed;
      nxt_q.rec_freq    = q_ff.freq_ref;
    end
  end

  // the single state register
  always_ff @(posedge mclk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      q_ff      <= '0;
      q_ff.boot <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign drive_run       = q_ff.drive_run;
  assign dir_reverse     = q_ff.dir_rev;
  assign freq_ref        = q_ff.freq_ref;
  assign volt_ref        = q_ff.volt_ref;
  assign pid_setpoint    = q_ff.pid_sp;
  assign ramp_select     = q_ff.ramp_sel;
  assign active_step     = q_ff.step;
  assign pass_done       = q_ff.pass_done;
  assign nv_save         = q_ff.nv_save;
  assign nv_save_step    = q_ff.rec_step;
  assign nv_save_elapsed = q_ff.rec_elapsed;
  assign nv_save_freq    = q_ff.rec_freq;

  // checks on the sequencing
  a_mode0_halts: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && nxt_q.pass_done && !stop_cmd
     && sequence_run_mode == MODE_STOP_END)
    |=> (!drive_run && q_ff.state == ST_IDLE)
  ) else $error("mode 0 did not halt after a pass");

  a_hold_final: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_HOLD && !stop_cmd)
    |=> ($stable(freq_ref) && $stable(dir_reverse) && drive_run)
  ) else $error("held final values changed");

  a_repeat_wrap: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && nxt_q.pass_done && !stop_cmd
     && sequence_run_mode == MODE_REPEAT)
    |=> (active_step == STEP_FIRST && drive_run)
  ) else $error("repeat mode did not wrap to step 0");

  a_dir_sign: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && terminal_mode && !stop_cmd
     && out_target == TGT_FREQ)
    |=> (dir_reverse == $past(cur_ref[REF_W-1]))
  ) else $error("direction does not follow step sign");

  a_pid_pass: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && terminal_mode && !stop_cmd)
    |=> (pid_setpoint == $past(cur_ref))
  ) else $error("setpoint altered on pass-through");

  a_terminal_sel: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && terminal_mode && !stop_cmd)
    |=> (active_step == $past(terminal_step))
  ) else $error("terminal selection not applied");

  a_zero_skip: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && !terminal_mode && !stop_cmd
     && cur_dur == '0 && q_ff.step != STEP_LAST)
    |=> (active_step == 4'($past(q_ff.step) + 4'h1))
  ) else $error("zero-duration step not skipped");

  a_step_order: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && !terminal_mode && !stop_cmd
     && cur_dur != '0 && !step_done)
    |=> $stable(active_step)
  ) else $error("step advanced before its duration");

  a_fresh_start: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_IDLE && run_cmd && !stop_cmd
     && !q_ff.rec_valid)
    |=> (active_step == STEP_FIRST && drive_run)
  ) else $error("fresh start not at step 0");

  a_stop_record: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && stop_cmd && ret_stop && !power_fail)
    |=> (!drive_run && q_ff.rec_valid && nv_save_step == $past(q_ff.step))
  ) else $error("stop position not recorded");

  // a recorded stop point is where the next start resumes
  a_stop_resume: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_IDLE && run_cmd && !stop_cmd && ret_stop
     && q_ff.rec_valid)
    |=> (active_step == $past(nv_save_step) && drive_run)
  ) else $error("stop position not resumed");

  a_stop_fresh: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_IDLE && run_cmd && !stop_cmd && !ret_stop
     && !q_ff.rec_pwr)
    |=> (active_step == STEP_FIRST && drive_run)
  ) else $error("start without retention not at step 0");

  // power loss hands over the current step and frequency
  a_nv_capture: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (power_fail && ret_pwr)
    |=> (nv_save && nv_save_step == $past(q_ff.step)
         && nv_save_freq == $past(freq_ref))
  ) else $error("power-loss point not handed over");

  a_ramp_follow: assert property (
    @(posedge mclk) disable iff (!rst_i_b)
    (q_ff.state == ST_RUN && terminal_mode && !stop_cmd)
    |=> (ramp_select == $past(step_ramp_select[q_ff.step]))
  ) else $error("ramp set does not follow the step");

endmodule : mss_sequencer
`default_nettype wire

// [dv/mss_drive_model.sv]
// drive-side model: full-scale bases and the signed speed demand
`timescale 1ns/1ps
`default_nettype none
module mss_drive_model #(
  parameter logic [15:0] MAX_FREQ   = 16'h1388,
  parameter logic [15:0] RATED_VOLT = 16'h0DC0
) (
  input  wire logic          mclk,
  input  wire logic          drive_run,
  input  wire logic          dir_reverse,
  input  wire logic [15:0]   freq_ref,
  output logic      [15:0]   max_freq,
  output logic      [15:0]   rated_volt,
  output logic signed [16:0] speed_cmd
);
  // bases are fixed for the run; real drives load them from setup
  assign max_freq   = MAX_FREQ;
  assign rated_volt = RATED_VOLT;
  // a stopped drive demands nothing, whatever the reference says
  always_ff @(posedge mclk) begin
    if (!drive_run) speed_cmd <= 17'sh0;
    else if (dir_reverse) speed_cmd <= -$signed({1'b0, freq_ref});
    else speed_cmd <= $signed({1'b0, freq_ref});
  end
endmodule : mss_drive_model
`default_nettype wire

// [dv/multi_step_speed_sequencer_tb.sv]
// self-checking bench of the multi-step speed sequencer
`timescale 1ns/1ps
`default_nettype none
module multi_step_speed_sequencer_tb;
  import mss_pkg::*;
  localparam int unsigned TC = 4;  // short tenth-unit count for sim
  logic mclk, rst_b, step_time_unit, terminal_mode, run_cmd, stop_cmd;
  logic power_fail, nv_valid, drive_run, dir_reverse, pass_done, nv_save;
  logic [1:0] sequence_run_mode, sequence_retention_select, out_target;
  logic [1:0] ramp_select;
  logic [2:0] step0_source_select;
  logic [NUM_STEPS-1:0][REF_W-1:0]  step_reference;
  logic [NUM_STEPS-1:0][DUR_W-1:0]  step_duration;
  logic [NUM_STEPS-1:0][RAMP_W-1:0] step_ramp_select;
  logic [5:0][REF_W-1:0] step0_alt_ref;
  logic [STEP_W-1:0] terminal_step, nv_step, active_step, nv_save_step;
  logic [DUR_W-1:0]  nv_elapsed, nv_save_elapsed;
  logic [BASE_W-1:0] max_freq, rated_volt, freq_ref, volt_ref, nv_save_freq;
  logic [REF_W-1:0]  pid_setpoint;
  logic signed [16:0] speed_cmd;
  int fail_count, checks_done;
  logic [31:0] seed;

  mss_sequencer #(.TENTH_CYC(TC)) u_dut (.mclk, .rst_b, .sequence_run_mode,
    .sequence_retention_select, .step_reference, .step_duration,
    .step_ramp_select, .step_time_unit, .step0_source_select, .step0_alt_ref,
    .out_target, .terminal_mode, .terminal_step, .run_cmd, .stop_cmd,
    .power_fail, .nv_valid, .nv_step, .nv_elapsed, .max_freq, .rated_volt,
    .drive_run, .dir_reverse, .freq_ref, .volt_ref, .pid_setpoint,
    .ramp_select, .active_step, .pass_done, .nv_save, .nv_save_step,
    .nv_save_elapsed, .nv_save_freq);
  mss_drive_model u_drive (.mclk, .drive_run, .dir_reverse, .freq_ref,
    .max_freq, .rated_volt, .speed_cmd);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // galois lfsr, fixed start so every run repeats
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic [REF_W-1:0] rnd_ref();
    return REF_W'(int'(rnd() % 32'h7D1) - int'(REF_FULL));
  endfunction : rnd_ref

  // magnitude scaled against a base, clamped at full scale, truncated
  function automatic logic [15:0] mag(input logic [REF_W-1:0] r,
                                      input logic [15:0] b);
    logic [31:0] a;
    a = r[REF_W-1] ? 32'(-$signed(r)) : 32'(r);
    if (a > 32'(REF_FULL)) a = 32'(REF_FULL);
    return 16'(a * 32'(b) / 32'(REF_FULL));
  endfunction : mag

  // step 0 may take its value from one of six alternate sources
  function automatic logic [REF_W-1:0] exp_ref(input int k);
    if (k == 0 && step0_source_select != 3'h0 && step0_source_select != 3'h7)
      return step0_alt_ref[step0_source_select - 3'h1];
    return step_reference[k];
  endfunction : exp_ref

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic give_up();
    fail_count++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    conclude();
  endtask : give_up

  // bounded poll for a running step index
  task automatic wait_step(input logic [3:0] k, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      if (active_step === k && drive_run === 1'b1) return;
    end
    give_up();
  endtask : wait_step

  // look before waiting: a one-cycle pulse may already stand on entry
  task automatic wait_sig(ref logic s, input int n);
    for (int i = 0; i < n; i++) begin
      if (s === 1'b1) return;
      @(negedge mclk);
    end
    give_up();
  endtask : wait_sig

  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask : pulse

  task automatic do_reset();
    rst_b = 1'b0;
    cyc(3);
    rst_b = 1'b1;
    cyc(4);
  endtask : do_reset

  // one random program, checked step by step and at the end of the pass
  task automatic run_pass(input logic [1:0] md, input logic [1:0] tg);
    logic [REF_W-1:0] r;
    logic [31:0] x;
    sequence_run_mode = md;
    out_target = tg;
    for (int k = 0; k < 16; k++) begin
      x = rnd();
      step_reference[k] = rnd_ref();
      step_duration[k] = (k == 0 || k == 15) ? 16'h2 :
                         (x[17:16] == 2'h0) ? 16'h0 : 16'(2 + x[18]);
      step_ramp_select[k] = x[21:20];
    end
    for (int j = 0; j < 6; j++) step0_alt_ref[j] = rnd_ref();
    pulse(run_cmd);
    for (int k = 0; k < 16; k++) begin
      if (step_duration[k] != 16'h0) begin
        wait_step(4'(k), 200);
        cyc(3);
        r = exp_ref(k);
        chk(freq_ref, mag(r, max_freq));
        chk(volt_ref, mag(r, rated_volt));
        chk(16'(pid_setpoint), 16'(r));
        chk(16'(dir_reverse), 16'(tg == TGT_FREQ && r[REF_W-1]));
        chk(16'(speed_cmd[16]), 16'(dir_reverse && freq_ref != 16'h0));
        chk(16'(ramp_select), 16'(step_ramp_select[k]));
      end
    end
    wait_sig(pass_done, 60);
    cyc(2);
    chk(16'(drive_run), 16'(md != MODE_STOP_END));
    chk(16'(active_step), (md == MODE_HOLD_END) ? 16'hF : 16'h0);
    if (md == MODE_HOLD_END) begin
      chk(freq_ref, mag(exp_ref(15), max_freq));
    end
    if (md == MODE_STOP_END) begin
      cyc(20);
      chk(16'(drive_run), 16'h0);
    end else begin
      pulse(stop_cmd);
      chk(16'(drive_run), 16'h0);
    end
  endtask : run_pass

  initial begin
    seed = 32'h1302;
    fail_count = 0;
    checks_done = 0;
    {run_cmd, stop_cmd, power_fail, nv_valid, terminal_mode} = 5'h0;
    {step_time_unit, step0_source_select, out_target} = 6'h0;
    {sequence_run_mode, sequence_retention_select} = 4'h0;
    {terminal_step, nv_step, nv_elapsed} = 24'h0;
    step_reference = '0;
    step_duration = '0;
    step_ramp_select = '0;
    step0_alt_ref = '0;
    do_reset();
    chk(freq_ref, 16'h0);
    // every source, mode and target, random programs
    for (int i = 0; i < 9; i++) begin
      step0_source_select = 3'(i);
      run_pass(2'(i % 3), 2'((i + 1) % 3));
    end
    // stop retention on, then off: resume point versus first step
    sequence_run_mode = MODE_REPEAT;
    for (int k = 0; k < 16; k++) step_duration[k] = 16'h2;
    for (int b = 1; b >= 0; b--) begin
      sequence_retention_select = {1'(b), 1'b0};
      pulse(run_cmd);
      wait_step(4'h5, 200);
      pulse(stop_cmd);
      if (b == 1) chk(16'(nv_save_step), 16'h5);
      if (b == 1) chk(nv_save_freq, mag(exp_ref(5), max_freq));
      pulse(run_cmd);
      chk(16'(active_step), (b == 1) ? 16'h5 : 16'h0);
      pulse(stop_cmd);
    end
    // power loss saves the point; resume only with the units digit set
    sequence_retention_select = 2'h1;
    pulse(run_cmd);
    wait_step(4'h7, 200);
    pulse(power_fail);
    wait_sig(nv_save, 5);
    chk(16'(nv_save_step), 16'h7);
    chk(nv_save_freq, mag(exp_ref(7), max_freq));
    chk(nv_save_elapsed, 16'h0);
    nv_valid = 1'b1;
    nv_step = nv_save_step;
    for (int b = 1; b >= 0; b--) begin
      sequence_retention_select = {1'b0, 1'(b)};
      do_reset();
      pulse(run_cmd);
      chk(16'(active_step), (b == 1) ? 16'h7 : 16'h0);
      pulse(stop_cmd);
    end
    nv_valid = 1'b0;
    // terminal selection overrides timing
    terminal_mode = 1'b1;
    pulse(run_cmd);
    for (int i = 0; i < 6; i++) begin
      terminal_step = 4'(rnd() >> 28);
      cyc(3);
      chk(16'(active_step), 16'(terminal_step));
      chk(16'(pid_setpoint), 16'(exp_ref(int'(terminal_step))));
    end
    pulse(stop_cmd);
    terminal_mode = 1'b0;
    // hour units: one tenth lasts 3600 times longer than in seconds
    step_time_unit = 1'b1;
    for (int k = 0; k < 16; k++) step_duration[k] = 16'h1;
    pulse(run_cmd);
    cyc(14000);
    chk(16'(active_step), 16'h0);
    wait_step(4'h1, 800);
    pulse(stop_cmd);
    conclude();
  end
endmodule : multi_step_speed_sequencer_tb
`default_nettype wire
